// *** pdb_core.sv ***
// DMA bridge core: routing, read/write channels, lite slave, interrupts
// How it works
// RULE1: One down and one up engine; mm_mode picks shared MM or stream.
// RULE2: Down channel reads the host and hands data to the user side.
// RULE3: Up channel gets user data, by stream or MM read, then writes host.
// RULE4: Host writes hitting the bypass BAR are forwarded on the bypass port.
// RULE5: Requests routed by BAR; non-posted reads answered on completer bus.
// RULE6: BAR numbering follows which spaces exist and their 32/64-bit size.
// RULE7: Read requests split at max read size and free buffer space.
// RULE8: Outstanding down reads capped; every split piece uses a tag.
// RULE9: Tag held from issue until its last user word is taken, in order.
// RULE10: Finished transfer gives a status writeback or an interrupt.
// RULE11: Buffer space reserved at issue; completions land in that space.
// RULE12: User words start on first data, bursts cut at payload size in MM mode.
// RULE13: Stream up data taken only when a descriptor is armed and enabled.
// RULE14: Up ids taken at MM read issue, freed when host write is sent.
// RULE15: Lite master does single 32-bit accesses, reads answered to host.
// RULE16: Lite slave reaches internal registers; in bridge mode bit 28 picks bank.
// RULE17: User and channel interrupt inputs become legacy, MSI or MSI-X.
// RULE18: User holds a legacy request bit until its first acknowledge.
// RULE19: Legacy drop sends deassert and a second acknowledge.
// RULE20: Each interrupt source maps to one of four legacy lines.
// RULE21: MSI or MSI-X message per request; MSI-X wins when both on.
// RULE22: MSI request held until acknowledged after message is sent.
// RULE23: Acknowledge is a one-cycle pulse for the sent bit only.
`include "pdb_consts.svh"
module pdb_core import pdb_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire pdb_barcfg_s bar_cfg,
  input  wire logic        bridge_mode,
  input  wire logic        mm_mode,
  input  wire logic        msi_en,
  input  wire logic        msix_en,
  input  wire logic        wb_en,
  input  wire logic [31:0] wb_addr,
  input  wire logic        creq_valid,
  input  wire pdb_creq_s   creq,
  output logic             creq_ready,
  output logic             ccpl_valid,
  output pdb_ccpl_s        ccpl,
  input  wire logic        ccpl_ready,
  output logic             lm_valid,
  output pdb_lreq_s        lm_req,
  input  wire logic        lm_ready,
  input  wire logic        lm_rvalid,
  input  wire logic [31:0] lm_rdata,
  output logic             byp_valid,
  output pdb_creq_s        byp_req,
  input  wire logic        byp_ready,
  input  wire logic        byp_rvalid,
  input  wire logic [31:0] byp_rdata,
  output logic             rreq_valid,
  output pdb_rreq_s        rreq,
  input  wire logic        rreq_ready,
  input  wire logic        rcpl_valid,
  input  wire pdb_rcpl_s   rcpl,
  input  wire logic        up_wsent,
  input  wire logic        dn_start,
  input  wire logic [31:0] dn_addr,
  input  wire logic [11:0] dn_len,
  output logic             dn_out_valid,
  output logic [31:0]      dn_out_data,
  output logic             dn_out_last,
  input  wire logic        dn_out_ready,
  input  wire logic        up_start,
  input  wire logic        up_en,
  input  wire logic [31:0] up_addr,
  input  wire logic [31:0] up_uaddr,
  input  wire logic [11:0] up_len,
  input  wire logic        up_in_valid,
  input  wire logic [31:0] up_in_data,
  output logic             up_in_ready,
  output logic             mr_valid,
  output logic [31:0]      mr_addr,
  input  wire logic        mr_ready,
  input  wire logic        mr_rvalid,
  input  wire logic [31:0] mr_rdata,
  output logic             mr_rready,
  input  wire logic        ls_valid,
  input  wire pdb_lreq_s   ls_req,
  output logic             ls_ready,
  output logic             ls_rvalid,
  output logic [31:0]      ls_rdata,
  input  wire logic        ls_rready,
  input  wire logic [3:0]  usr_irq_req,
  output logic [3:0]       usr_irq_ack,
  output logic             irq_valid,
  output pdb_msg_s         irq_msg,
  input  wire logic        irq_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  function automatic pdb_tgt_e pdb_route(input logic [2:0] bar,
                                          input pdb_barcfg_s c);
    logic [2:0] dma_bar;
    logic [2:0] byp_bar;
    dma_bar = !c.lite_en ? `PDB_BAR_LITE :
              c.lite64 ? `PDB_BAR_STEP64 : `PDB_BAR_STEP32;
    byp_bar = dma_bar + (c.dma64 ? `PDB_BAR_STEP64 : `PDB_BAR_STEP32);
    if (c.lite_en && bar == `PDB_BAR_LITE) return PDB_T_LITE;
    if (bar == dma_bar) return PDB_T_DMA;
    if (c.byp_en && bar == byp_bar) return PDB_T_BYP;
    return PDB_T_NONE;
  endfunction : pdb_route

  function automatic logic [2:0] pdb_first(input logic [5:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = `PDB_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = 3'(i);
    end
    return r;
  endfunction : pdb_first

  // Target bridge: one host request in flight at a time
  pdb_tb_e    tb_r, tb_nxt;
  pdb_tgt_e   tgt_r, cq_tgt;
  pdb_creq_s  cq_r;
  logic [31:0] cpl_r, stat_w, rsp_d;
  logic        cq_take, fwd_fire, rsp_v;
  assign cq_tgt     = pdb_route(creq.bar, bar_cfg); // RULE6
  assign creq_ready = (tb_r == TB_IDLE);
  assign cq_take    = creq_valid & creq_ready;
  assign fwd_fire   = (tgt_r == PDB_T_LITE) ? lm_ready : byp_ready;
  assign rsp_v      = (tgt_r == PDB_T_LITE) ? lm_rvalid : byp_rvalid;
  assign rsp_d      = (tgt_r == PDB_T_LITE) ? lm_rdata : byp_rdata;
  assign lm_valid   = (tb_r == TB_FWD) & (tgt_r == PDB_T_LITE); // RULE15
  assign lm_req     = '{wr: cq_r.wr, addr: cq_r.addr, data: cq_r.data};
  assign byp_valid  = (tb_r == TB_FWD) & (tgt_r == PDB_T_BYP); // RULE4
  assign byp_req    = cq_r;
  assign ccpl_valid = (tb_r == TB_CPL); // RULE5
  assign ccpl       = '{tag: cq_r.tag, data: cpl_r};
  always_comb begin
    tb_nxt = tb_r;
    unique case (tb_r)
      TB_IDLE: if (cq_take) begin // RULE5
        tb_nxt = (cq_tgt == PDB_T_LITE || cq_tgt == PDB_T_BYP) ? TB_FWD :
                 creq.wr ? TB_IDLE : TB_CPL;
      end
      TB_FWD:  if (fwd_fire) tb_nxt = cq_r.wr ? TB_IDLE : TB_WAIT;
      TB_WAIT: if (rsp_v) tb_nxt = TB_CPL;
      TB_CPL:  if (ccpl_ready) tb_nxt = TB_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tb_r  <= TB_IDLE;
      tgt_r <= PDB_T_DMA;
      cq_r  <= '0;
      cpl_r <= '0;
    end else begin
      tb_r <= tb_nxt;
      if (cq_take) begin
        cq_r  <= creq;
        tgt_r <= cq_tgt;
        cpl_r <= (cq_tgt == PDB_T_DMA) ? stat_w : '0;
      end else if (tb_r == TB_WAIT && rsp_v) begin
        cpl_r <= rsp_d;
      end
    end
  end

  // Down channel: host reads into a reserved buffer slice per tag
  logic        rr_valid_r, rr_load, wb_pend_r, wb_go;
  logic [1:0]  wb_stat_r, chan_irq_r;
  pdb_rreq_s   rr_r;
  logic [32:0] sk_d_r [2];
  logic [1:0]  sk_cnt_r, sk_after;
  logic [11:0] dn_rem_r, dn_left_r;
  logic [31:0] dn_addr_r;
  logic [1:0]  dn_tail_r, dn_rdtag_r;
  logic [2:0]  dn_cnt_r;
  logic [4:0]  dn_alloc_r, dn_rptr_r, dn_free;
  logic [7:0]  dn_sent_r, dn_beat_r, dn_chunk, dn_cap;
  logic [3:0]  dn_base_r [`PDB_TAGS];
  logic [7:0]  dn_len_r  [`PDB_TAGS];
  logic [7:0]  dn_got_r  [`PDB_TAGS];
  logic        dn_issue, dn_rd_go, dn_tl, dn_adv, rdp_r, rdp_tl_r;
  logic        dn_pop, dn_retire, dn_done;
  logic [31:0] mem_q;
  assign dn_free  = `PDB_BUF_WORDS - (dn_alloc_r - dn_rptr_r);
  assign dn_cap   = (dn_rem_r < 12'(`PDB_MRRS)) ? dn_rem_r[7:0] : `PDB_MRRS;
  assign dn_chunk = ({3'h0, dn_free} < dn_cap) ? {3'h0, dn_free} : dn_cap; // RULE7
  // Tags reused only after retire, so a full tag table stalls issue
  assign dn_issue = rr_load & ~wb_pend_r & (dn_chunk != '0) &
                    (dn_cnt_r < `PDB_TAGS); // RULE8
  assign dn_tl    = (dn_sent_r + 8'h1 == dn_len_r[dn_rdtag_r]);
  assign dn_rd_go = (dn_sent_r < dn_got_r[dn_rdtag_r]) &
                    ({1'b0, sk_cnt_r} + {2'h0, rdp_r} < {1'b0, `PDB_SK_FULL}); // RULE12
  assign dn_adv   = dn_rd_go & dn_tl;
  assign dn_pop   = dn_out_valid & dn_out_ready;
  assign dn_retire = dn_pop & sk_d_r[0][32]; // RULE9
  assign dn_done  = dn_pop & (dn_left_r == 12'h1);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dn_rem_r <= '0; dn_left_r <= '0; dn_addr_r <= '0;
      dn_tail_r <= '0; dn_rdtag_r <= '0; dn_cnt_r <= '0;
      dn_alloc_r <= '0; dn_rptr_r <= '0; dn_sent_r <= '0;
      dn_beat_r <= '0; rdp_r <= 1'b0; rdp_tl_r <= 1'b0;
      for (int t = 0; t < `PDB_TAGS; t++) begin
        dn_base_r[t] <= '0; dn_len_r[t] <= '0; dn_got_r[t] <= '0;
      end
    end else begin
      rdp_r    <= dn_rd_go;
      rdp_tl_r <= dn_tl;
      dn_cnt_r <= dn_cnt_r + {2'h0, dn_issue} - {2'h0, dn_retire};
      if (dn_start) begin
        dn_rem_r  <= dn_len;
        dn_left_r <= dn_len;
        dn_addr_r <= dn_addr;
      end else begin
        if (dn_issue) begin // RULE11
          dn_rem_r  <= dn_rem_r - {4'h0, dn_chunk};
          dn_addr_r <= dn_addr_r + {22'h0, dn_chunk, 2'h0};
          dn_tail_r <= dn_tail_r + 2'h1;
          dn_alloc_r <= dn_alloc_r + dn_chunk[4:0];
          dn_base_r[dn_tail_r] <= dn_alloc_r[3:0];
          dn_len_r[dn_tail_r]  <= dn_chunk;
        end
        if (dn_pop) dn_left_r <= dn_left_r - 12'h1;
      end
      if (rcpl_valid) dn_got_r[rcpl.tag] <= dn_got_r[rcpl.tag] + 8'h1;
      if (dn_adv) dn_got_r[dn_rdtag_r] <= '0;
      if (dn_rd_go) begin
        dn_rptr_r  <= dn_rptr_r + 5'h1;
        dn_sent_r  <= dn_tl ? 8'h0 : dn_sent_r + 8'h1;
        dn_rdtag_r <= dn_rdtag_r + {1'b0, dn_tl};
      end
      if (dn_pop) dn_beat_r <= dn_out_last ? 8'h0 : dn_beat_r + 8'h1;
    end
  end
  pdb_buf_mem u_mem (
    .mclk   (mclk),
    .resetn (resetn),
    .we     (rcpl_valid),
    .waddr  (dn_base_r[rcpl.tag] + dn_got_r[rcpl.tag][3:0]), // RULE11
    .wdata  (rcpl.data),
    .raddr  (dn_rptr_r[3:0]),
    .rdata  (mem_q)
  );

  // Two-entry buffer so a user stall loses no word already read
  assign sk_after     = sk_cnt_r - {1'b0, dn_pop};
  assign dn_out_valid = (sk_cnt_r != 2'h0); // RULE2
  assign dn_out_data  = sk_d_r[0][31:0];
  // Stream side sees no payload-size cut, only the transfer end
  assign dn_out_last  = (dn_left_r == 12'h1) |
                        (mm_mode & (dn_beat_r == `PDB_MPS - 8'h1)); // RULE12
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sk_cnt_r <= '0; sk_d_r[0] <= '0; sk_d_r[1] <= '0;
    end else begin
      sk_cnt_r <= sk_after + {1'b0, rdp_r};
      if (dn_pop) sk_d_r[0] <= (sk_cnt_r == `PDB_SK_FULL) ? sk_d_r[1] :
                                {rdp_tl_r, mem_q};
      else if (sk_cnt_r == 2'h0) sk_d_r[0] <= {rdp_tl_r, mem_q};
      if (rdp_r && sk_after == 2'h1) sk_d_r[1] <= {rdp_tl_r, mem_q};
    end
  end

  // Up channel: one staged word toward the host write path
  logic        up_armed_r, up_have_r, up_go, up_done, up_take, mr_take;
  logic [11:0] up_rem_r, up_mrem_r;
  logic [31:0] up_pa_r, up_ua_r, up_dat_r;
  logic [2:0]  up_ids_r;
  assign up_in_ready = up_armed_r & up_en & ~mm_mode & ~up_have_r; // RULE13
  assign up_take   = up_in_valid & up_in_ready;
  assign mr_valid  = up_armed_r & up_en & mm_mode & (up_mrem_r != '0) &
                     (up_ids_r < `PDB_UP_IDS); // RULE14
  assign mr_addr   = up_ua_r; // RULE1
  assign mr_rready = ~up_have_r;
  assign mr_take   = mr_valid & mr_ready;
  assign up_go     = up_have_r & rr_load & ~wb_pend_r & ~dn_issue; // RULE3
  assign up_done   = up_go & (up_rem_r == 12'h1);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      up_armed_r <= 1'b0; up_have_r <= 1'b0; up_rem_r <= '0;
      up_mrem_r <= '0; up_pa_r <= '0; up_ua_r <= '0;
      up_dat_r <= '0; up_ids_r <= '0;
    end else begin
      up_ids_r <= up_ids_r + {2'h0, mr_take} -
                  {2'h0, up_wsent & (up_ids_r != 3'h0)}; // RULE14
      if (up_start) begin
        up_armed_r <= 1'b1; up_rem_r <= up_len; up_mrem_r <= up_len;
        up_pa_r <= up_addr; up_ua_r <= up_uaddr;
      end else begin
        if (mr_take) begin
          up_mrem_r <= up_mrem_r - 12'h1;
          up_ua_r   <= up_ua_r + `PDB_WORD_B;
        end
        if (up_go) begin
          up_rem_r <= up_rem_r - 12'h1;
          up_pa_r  <= up_pa_r + `PDB_WORD_B;
        end
        if (up_done) up_armed_r <= 1'b0;
      end
      if (up_take || (mr_rvalid && mr_rready)) begin
        up_have_r <= 1'b1;
        up_dat_r  <= up_take ? up_in_data : mr_rdata;
      end else if (up_go) begin
        up_have_r <= 1'b0;
      end
    end
  end

  // Requester request register; writeback beats reads beats up writes
  assign rr_load    = ~rr_valid_r | rreq_ready;
  assign wb_go      = wb_pend_r & rr_load;
  assign rreq_valid = rr_valid_r;
  assign rreq       = rr_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rr_valid_r <= 1'b0; rr_r <= '0;
      wb_pend_r <= 1'b0; wb_stat_r <= '0;
    end else begin
      if (rr_load) rr_valid_r <= wb_go | dn_issue | up_go;
      if (wb_go) begin // RULE10
        rr_r <= '{wr: 1'b1, addr: wb_addr, len: 8'h1, tag: '0,
                  data: {30'h0, wb_stat_r}};
      end else if (dn_issue) begin // RULE2
        rr_r <= '{wr: 1'b0, addr: dn_addr_r, len: dn_chunk,
                  tag: {2'h0, dn_tail_r}, data: '0};
      end else if (up_go) begin // RULE3
        rr_r <= '{wr: 1'b1, addr: up_pa_r, len: 8'h1, tag: '0,
                  data: up_dat_r};
      end
      // A finish in the launch cycle re-arms the writeback
      if (wb_en && (dn_done || up_done)) begin // RULE10
        wb_pend_r <= 1'b1;
        wb_stat_r <= (wb_go ? 2'h0 : wb_stat_r) | {up_done, dn_done};
      end else if (wb_go) begin
        wb_pend_r <= 1'b0;
        wb_stat_r <= '0;
      end
    end
  end

  // Lite slave: internal registers only, never a host request
  logic [11:0] map_r;
  logic        ls_rv_r, ls_dma, ls_take;
  logic [31:0] ls_q_r, ls_rd_w;
  assign stat_w   = {16'h0, 1'b0, dn_cnt_r, 1'b0, up_ids_r, 6'h0,
                     up_armed_r, (dn_left_r != '0)};
  assign ls_ready = ~ls_rv_r;
  assign ls_take  = ls_valid & ls_ready;
  assign ls_dma   = ~bridge_mode | ls_req.addr[`PDB_LS_SEL]; // RULE16
  assign ls_rd_w  = !ls_dma ?
      ((ls_req.addr[11:0] == `PDB_LS_BAR) ? {28'h0, bar_cfg} : '0) :
      (ls_req.addr[11:0] == `PDB_LS_STAT) ? stat_w :
      (ls_req.addr[11:0] == `PDB_LS_MAP) ? {20'h0, map_r} : '0;
  assign ls_rvalid = ls_rv_r;
  assign ls_rdata  = ls_q_r;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ls_rv_r <= 1'b0; ls_q_r <= '0; map_r <= `PDB_MAP_RST;
    end else begin
      if (ls_take) begin
        ls_rv_r <= 1'b1;
        ls_q_r  <= ls_req.wr ? '0 : ls_rd_w;
      end else if (ls_rready) begin
        ls_rv_r <= 1'b0;
      end
      if (ls_take && ls_req.wr && ls_dma &&
          ls_req.addr[11:0] == `PDB_LS_MAP) begin
        map_r <= ls_req.data[11:0]; // RULE20
      end
    end
  end

  // Interrupts: per-source handshake, one message in flight
  pdb_iq_e   iq_r [`PDB_NUM_SRC];
  pdb_iq_e   iq_nxt [`PDB_NUM_SRC];
  logic [5:0] src_req, want;
  logic [2:0] pick_idx;
  logic       msg_v_r, msg_done, pick_v, legacy;
  pdb_msg_s   msg_r;
  pdb_kind_e  kind_w;
  assign kind_w  = msix_en ? PDB_K_MSIX : msi_en ? PDB_K_MSI : PDB_K_LEG; // RULE21
  assign legacy  = (kind_w == PDB_K_LEG);
  assign src_req = {chan_irq_r, usr_irq_req}; // RULE17
  assign pick_v  = ~msg_v_r & (want != '0);
  assign pick_idx = pdb_first(want);
  assign msg_done = msg_v_r & irq_ready;
  assign irq_valid = msg_v_r;
  assign irq_msg   = msg_r;
  genvar gi;
  for (gi = 0; gi < `PDB_NUM_SRC; gi++) begin : g_iq
    logic pick_me, done_me;
    assign pick_me  = pick_v & (pick_idx == 3'(gi));
    assign done_me  = msg_done & (msg_r.src == 3'(gi));
    assign want[gi] = ((iq_r[gi] == IQ_IDLE) & src_req[gi]) |
                      ((iq_r[gi] == IQ_HELD) & ~src_req[gi] & legacy);
    always_comb begin
      iq_nxt[gi] = iq_r[gi];
      unique case (iq_r[gi])
        IQ_IDLE:   if (pick_me) iq_nxt[gi] = IQ_SEND;
        IQ_SEND:   if (done_me) iq_nxt[gi] = IQ_HELD; // RULE22
        IQ_HELD:   if (pick_me) iq_nxt[gi] = IQ_UNSEND; // RULE19
                   else if (!src_req[gi] && !legacy) iq_nxt[gi] = IQ_IDLE;
        IQ_UNSEND: if (done_me) iq_nxt[gi] = IQ_IDLE; // RULE19
      endcase
    end
    always_ff @(posedge mclk) begin
      if (!resetn) iq_r[gi] <= IQ_IDLE;
      else iq_r[gi] <= iq_nxt[gi];
    end
    if (gi < `PDB_NUM_USR) begin : g_ack
      assign usr_irq_ack[gi] = done_me; // RULE23
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      msg_v_r <= 1'b0; msg_r <= '0; chan_irq_r <= '0;
    end else begin
      if (pick_v) begin
        msg_v_r <= 1'b1;
        msg_r   <= '{kind: kind_w, src: pick_idx,
                     line: map_r[{pick_idx, 1'b0} +: 2], // RULE20
                     asrt: (iq_r[pick_idx] == IQ_IDLE)};
      end else if (msg_done) begin
        msg_v_r <= 1'b0;
      end
      // A new finish wins over the acknowledge that clears the flag
      for (int c = 0; c < 2; c++) begin
        if (!wb_en && (c == 0 ? dn_done : up_done)) chan_irq_r[c] <= 1'b1;
        else if (msg_done && msg_r.asrt &&
                 msg_r.src == 3'(`PDB_NUM_USR + c)) chan_irq_r[c] <= 1'b0;
      end
    end
  end

  a_rreq_stable: assert property ( // RULE2
    rreq_valid && !rreq_ready |=> rreq_valid && $stable(rreq))
    else $error("request changed while stalled");
  a_tag_cap: assert property (dn_cnt_r <= `PDB_TAGS) // RULE8
    else $error("too many outstanding reads");
  a_read_size: assert property ( // RULE7
    rreq_valid && !rreq.wr |-> rreq.len <= `PDB_MRRS && rreq.len != '0)
    else $error("read request size out of range");
  a_up_gate: assert property ( // RULE13
    up_in_valid && up_in_ready |-> up_armed_r && up_en && !mm_mode)
    else $error("stream data taken while not armed");
  a_up_ids: assert property (up_ids_r <= `PDB_UP_IDS) // RULE14
    else $error("too many up ids");
  a_ack_pulse: assert property ( // RULE23
    usr_irq_ack != '0 |-> $onehot(usr_irq_ack) ##1 usr_irq_ack == '0)
    else $error("acknowledge not a single pulse");
  a_msix_pref: assert property ( // RULE21
    $rose(irq_valid) && msix_en |-> irq_msg.kind == PDB_K_MSIX)
    else $error("MSI-X not preferred");
  a_lite_route: assert property ( // RULE15
    creq_valid && creq_ready && cq_tgt == PDB_T_LITE |=> lm_valid)
    else $error("lite request not forwarded");
  a_byp_route: assert property ( // RULE4
    creq_valid && creq_ready && cq_tgt == PDB_T_BYP |=> byp_valid)
    else $error("bypass request not forwarded");
  a_cpl_after: assert property ( // RULE5
    tb_r == TB_WAIT && rsp_v |=> ccpl_valid && ccpl.data == $past(rsp_d))
    else $error("completion missing after read data");
  c_dn_done: cover property (dn_done);
  c_up_done: cover property (up_done);
  c_legacy_deassert: cover property (msg_done && legacy && !msg_r.asrt);
  c_cpl_sent: cover property (ccpl_valid && ccpl_ready);
endmodule : pdb_core

// *** pdb_consts.svh ***
// Named constants of the DMA bridge core
`ifndef PDB_CONSTS_SVH
`define PDB_CONSTS_SVH
`define PDB_NUM_USR    4
`define PDB_NUM_SRC    6
`define PDB_TAGS       3'h4
`define PDB_UP_IDS     3'h4
`define PDB_BUF_N      16
`define PDB_BUF_WORDS  5'h10
`define PDB_MRRS       8'h08
`define PDB_MPS        8'h04
`define PDB_WORD_B     32'h4
`define PDB_BAR_LITE   3'h0
`define PDB_BAR_STEP32 3'h1
`define PDB_BAR_STEP64 3'h2
`define PDB_LS_SEL     28
`define PDB_LS_STAT    12'h000
`define PDB_LS_MAP     12'h004
`define PDB_LS_BAR     12'h000
`define PDB_MAP_RST    12'h000
`define PDB_SK_FULL    2'h2
`endif

// *** pdb_pkg.sv ***
// Types shared by the DMA bridge core
`include "pdb_consts.svh"
package pdb_pkg;
  typedef enum logic [1:0] {
    PDB_T_DMA, PDB_T_LITE, PDB_T_BYP, PDB_T_NONE
  } pdb_tgt_e;
  typedef enum logic [1:0] {
    TB_IDLE = 2'b00, TB_FWD = 2'b01, TB_WAIT = 2'b11, TB_CPL = 2'b10
  } pdb_tb_e;
  typedef enum logic [1:0] {
    IQ_IDLE = 2'b00, IQ_SEND = 2'b01, IQ_HELD = 2'b11, IQ_UNSEND = 2'b10
  } pdb_iq_e;
  typedef enum logic [1:0] {PDB_K_LEG, PDB_K_MSI, PDB_K_MSIX} pdb_kind_e;
  typedef struct packed {
    logic lite_en; logic byp_en; logic lite64; logic dma64;
  } pdb_barcfg_s;
  typedef struct packed {
    logic [2:0] bar; logic wr; logic [31:0] addr;
    logic [31:0] data; logic [7:0] tag;
  } pdb_creq_s;
  typedef struct packed {
    logic [7:0] tag; logic [31:0] data;
  } pdb_ccpl_s;
  typedef struct packed {
    logic wr; logic [31:0] addr; logic [7:0] len;
    logic [3:0] tag; logic [31:0] data;
  } pdb_rreq_s;
  typedef struct packed {
    logic [1:0] tag; logic [31:0] data;
  } pdb_rcpl_s;
  typedef struct packed {
    logic wr; logic [31:0] addr; logic [31:0] data;
  } pdb_lreq_s;
  typedef struct packed {
    pdb_kind_e kind; logic [2:0] src; logic [1:0] line; logic asrt;
  } pdb_msg_s;
endpackage : pdb_pkg

// *** pdb_buf_mem.sv ***
// Completion data buffer with registered read port
`include "pdb_consts.svh"
module pdb_buf_mem import pdb_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  raddr,
  output logic      [31:0] rdata
);
  logic [31:0] mem_r [`PDB_BUF_N];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem_r[raddr];
    end
  end
endmodule : pdb_buf_mem

// *** pdb_far.sv ***
// Host memory model answering requester reads, one word per cycle
module pdb_far import pdb_pkg::*; (
  input  wire logic      mclk,
  input  wire logic      resetn,
  input  wire logic      rreq_valid,
  input  wire pdb_rreq_s rreq,
  output logic           rreq_ready,
  output logic           rcpl_valid,
  output pdb_rcpl_s      rcpl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  left_r;
  logic [31:0] a_r;
  // Busy while answering, so a second read waits
  assign rreq_ready = (left_r == 8'h00);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      left_r <= 8'h00;
      rcpl_valid <= 1'b0;
    end else if (rreq_valid && rreq_ready && !rreq.wr) begin
      left_r <= rreq.len;
      a_r <= rreq.addr;
      rcpl.tag <= rreq.tag[1:0];
      rcpl_valid <= 1'b0;
    end else if (left_r != 8'h00) begin
      rcpl_valid <= 1'b1;
      rcpl.data <= a_r;
      a_r <= a_r + 32'h4;
      left_r <= left_r - 8'h01;
    end else begin
      rcpl_valid <= 1'b0;
      // Stale word must not look valid
      rcpl.data <= ~rcpl.data;
    end
  end
endmodule : pdb_far

// *** pdb_core_tb.sv ***
// Self-checking bench for the DMA bridge core
module pdb_core_tb import pdb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn, bridge_mode, mm_mode, msi_en, msix_en, wb_en, creq_valid;
  logic creq_ready, ccpl_valid, ccpl_ready, lm_valid, lm_ready, lm_rvalid;
  logic byp_valid, byp_ready, byp_rvalid, rreq_valid, rreq_ready;
  logic rcpl_valid, up_wsent, dn_start, dn_out_valid, dn_out_last;
  logic dn_out_ready, up_start, up_en, up_in_valid, up_in_ready, mr_valid;
  logic mr_ready, mr_rvalid, mr_rready, ls_valid, ls_ready, ls_rvalid;
  logic ls_rready, irq_valid, irq_ready;
  logic [31:0] wb_addr, lm_rdata, byp_rdata, dn_addr, dn_out_data, up_addr;
  logic [31:0] up_uaddr, up_in_data, mr_addr, mr_rdata, ls_rdata;
  logic [11:0] dn_len, up_len;
  logic [3:0]  usr_irq_req, usr_irq_ack;
  pdb_barcfg_s bar_cfg;
  pdb_creq_s   creq, byp_req;
  pdb_ccpl_s   ccpl;
  pdb_lreq_s   lm_req, ls_req;
  pdb_rreq_s   rreq;
  pdb_rcpl_s   rcpl;
  pdb_msg_s    irq_msg;
  int          n, n_fail = 0, tests_run = 0;
  pdb_core pdb_core_i (.*);
  pdb_far  pdb_far_i (.*);
  always #20 mclk = ~mclk;
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Counts: %0d checks, %0d failures", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic need(logic ok);
    if (!ok) begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
  endtask : need
  task automatic host(logic [2:0] b, logic w, logic [31:0] d);
    creq = '{bar: b, wr: w, addr: 32'h10, data: d, tag: 8'h5a};
    creq_valid = 1'b1;
    for (n = 0; n < 40 && !creq_ready; n++) tick;
    need(n < 40);
    tick;
    creq_valid = 1'b0;
  endtask : host
  task automatic ls(logic w, logic [31:0] a, logic [31:0] d);
    ls_req = '{wr: w, addr: a, data: d};
    ls_valid = 1'b1;
    for (n = 0; n < 40 && !ls_ready; n++) tick;
    need(n < 40);
    tick;
    ls_valid = 1'b0;
    if (!w) chk(ls_rdata, d);
  endtask : ls
  initial begin
    {resetn, creq_valid, lm_rvalid, byp_rvalid, dn_start, up_start} = '0;
    {up_en, up_in_valid, mr_ready, mr_rvalid, ls_valid, up_wsent} = '0;
    {bridge_mode, mm_mode, wb_en, irq_ready, creq, ls_req} = '0;
    {msi_en, msix_en, ccpl_ready, lm_ready, byp_ready} = 5'h1f;
    {dn_out_ready, ls_rready, bar_cfg} = 6'h3c;
    {wb_addr, lm_rdata, byp_rdata, dn_addr, up_addr, up_uaddr} = '0;
    {up_in_data, mr_rdata, dn_len, up_len, usr_irq_req} = '0;
    repeat (4) tick;
    resetn = 1'b1;
    host(3'h0, 1'b0, 32'h0);
    chk({lm_valid, lm_req.wr, lm_req.addr[29:0]}, 32'h80000010);
    tick;
    lm_rvalid = 1'b1;
    lm_rdata = 32'ha5;
    tick;
    lm_rvalid = 1'b0;
    chk({ccpl_valid, ccpl.tag, ccpl.data[22:0]}, 32'had0000a5);
    host(3'h2, 1'b1, 32'h77);
    chk({byp_valid, byp_req.bar, byp_req.data[27:0]}, 32'ha0000077);
    bridge_mode = 1'b1;
    ls(1'b0, 32'h0, 32'hc);
    ls(1'b1, 32'h10000004, 32'h555);
    ls(1'b0, 32'h10000004, 32'h555);
    dn_addr = 32'h100;
    dn_len = 12'h2;
    dn_start = 1'b1;
    tick;
    dn_start = 1'b0;
    for (int k = 0; k < 2; k++) begin
      for (n = 0; n < 40 && !dn_out_valid; n++) tick;
      need(n < 40);
      chk(dn_out_data, 32'h100 + 32'(k) * 4);
      chk(32'(dn_out_last), 32'(k));
      tick;
    end
    for (n = 0; n < 40 && !irq_valid; n++) tick;
    need(n < 40);
    chk(32'({irq_msg.kind, irq_msg.src}), 32'h14);
    usr_irq_req = 4'h1;
    irq_ready = 1'b1;
    for (n = 0; n < 40 && !usr_irq_ack[0]; n++) tick;
    need(n < 40);
    chk(32'(irq_msg.kind), 32'(PDB_K_MSIX));
    tick;
    chk(32'(usr_irq_ack), 32'h0);
    usr_irq_req = 4'h0;
    tick;
    chk(32'(irq_valid), 32'h0);
    {msi_en, msix_en} = 2'h0;
    usr_irq_req = 4'h2;
    for (n = 0; n < 40 && !usr_irq_ack[1]; n++) tick;
    need(n < 40);
    chk(32'({usr_irq_ack, irq_msg.line, irq_msg.asrt}), 32'h13);
    tick;
    usr_irq_req = 4'h0;
    for (n = 0; n < 40 && !usr_irq_ack[1]; n++) tick;
    need(n < 40);
    chk(32'({irq_msg.line, irq_msg.asrt}), 32'h2);
    {up_en, wb_en, up_in_valid} = 3'h7;
    {wb_addr, up_addr, up_in_data} = {32'h300, 32'h200, 32'h33};
    up_len = 12'h1;
    up_start = 1'b1;
    chk(32'(up_in_ready), 32'h0);
    tick;
    up_start = 1'b0;
    for (n = 0; n < 40 && !up_in_ready; n++) tick;
    need(n < 40);
    tick;
    up_in_valid = 1'b0;
    tick;
    chk({rreq_valid, rreq.wr, rreq.addr[29:0]}, 32'hc0000200);
    chk(rreq.data, 32'h33);
    tick;
    chk({rreq_valid, rreq.wr, rreq.addr[29:0]}, 32'hc0000300);
    chk(rreq.data, 32'h2);
    {mm_mode, mr_ready, up_start} = 3'h7;
    up_uaddr = 32'h40;
    tick;
    up_start = 1'b0;
    chk({mr_valid, mr_addr[30:0]}, 32'h80000040);
    tick;
    {mr_rvalid, mr_rdata} = {1'b1, 32'h66};
    tick;
    mr_rvalid = 1'b0;
    tick;
    chk({rreq_valid, rreq.wr, rreq.addr[29:0]}, 32'hc0000200);
    chk(rreq.data, 32'h66);
    give_verdict;
  end
endmodule : pdb_core_tb
